// File: rtl/regulator_mode_config_regs.v
/*
 * Operating-mode registers for linear regulators five to fifteen, the
 * buck and buck-boost converters, and the first regulator's config.
 * Assumes the serial front end delivers decoded one-cycle write and read
 * strobes with an 8-bit address, synchronous to clk.
 */
// Notes on behaviour
// - each enable bit: 0 turns the regulator off, 1 turns it on
// - each low-power bit: 0 normal operation, 1 low-power operation
// - 0x11 holds pairs for regulators 8,7,6,5 from bit 7, enable upper
// - 0x12 holds pairs for regulators 12,11,10,9 from bit 7, enable upper
// - 0x13 holds pairs for 15,14,13 in bits 5:0; bits 7:6 reserved
// - 0x14 bit 3 switches buck-boost output; bits 7:4 and 2 reserved
// - converter register bit 1 switches the buck output on or off
// - converter register bit 0 selects buck low-power operation
// - all mode registers reset to zero: everything off, normal mode
// - 0x20 bit 7 enables active output discharge of regulator one
// - 0x20 bits 6:0 hold the voltage code, 12.5 mV per step from 0.6 V
// - configuration register resets to 0xa0, one volt, discharge on
`timescale 1ns/10ps
`default_nettype none
`include "regulator_mode_config_regs.vh"
module regulator_mode_config_regs (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // register access from the serial front end
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // regulator controls
  output reg  [10:0] ldo_output_on,
  output reg  [10:0] ldo_low_power,
  output reg         buckboost_output_on,
  output reg         buck_output_on,
  output reg         buck_low_power,
  output reg         reg1_active_discharge,
  output reg  [6:0]  reg1_voltage_code
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // output reset levels follow the register reset values
  localparam [7:0]  MODE_RESET  = `RST_LDO_MODE;
  localparam [7:0]  CONV_RESET  = `RST_CONVERTER_MODE;
  localparam [7:0]  CFG_RESET   = `RST_FIRST_LDO_CONFIG;
  localparam [7:0]  FULL_MASK   = 8'hff;
  localparam [21:0] RESET_PAIRS = {MODE_RESET[5:0], MODE_RESET, MODE_RESET};
  localparam        NUM_LDO     = 11;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // pick the enable (odd) or low-power (even) bit of every pair
  function [10:0] pick;
    input [21:0] packed_pairs;
    input        upper;
    integer      k;
    begin
      for (k = 0; k < NUM_LDO; k = k + 1) begin
        pick[k] = packed_pairs[2*k + upper];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // a write to an unmapped address raises no strobe and is lost
  wire wr_group2;
  wire wr_group3;
  wire wr_group4;
  wire wr_conv;
  wire wr_ldo1;

  assign wr_group2 = reg_wr & hit(reg_addr, `OFF_LDO_MODE_GROUP2);
  assign wr_group3 = reg_wr & hit(reg_addr, `OFF_LDO_MODE_GROUP3);
  assign wr_group4 = reg_wr & hit(reg_addr, `OFF_LDO_MODE_GROUP4);
  assign wr_conv   = reg_wr & hit(reg_addr, `OFF_CONVERTER_MODE);
  assign wr_ldo1   = reg_wr & hit(reg_addr, `OFF_FIRST_LDO_CONFIG);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // reserved bits are masked inside the cell, so they read back zero
  wire [7:0] group2;
  wire [7:0] group3;
  wire [7:0] group4;
  wire [7:0] conv_mode;
  wire [7:0] first_ldo_config;

  reg8_cell #(
    .RESET_VALUE (MODE_RESET),
    .WRITE_MASK  (FULL_MASK)
  ) u_group2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_group2),
    .wr_data (reg_wdata),
    .value   (group2)
  );

  reg8_cell #(
    .RESET_VALUE (MODE_RESET),
    .WRITE_MASK  (FULL_MASK)
  ) u_group3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_group3),
    .wr_data (reg_wdata),
    .value   (group3)
  );

  reg8_cell #(
    .RESET_VALUE (MODE_RESET),
    .WRITE_MASK  (`MASK_LDO_MODE_GROUP4)
  ) u_group4 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_group4),
    .wr_data (reg_wdata),
    .value   (group4)
  );

  reg8_cell #(
    .RESET_VALUE (CONV_RESET),
    .WRITE_MASK  (`MASK_CONVERTER_MODE)
  ) u_conv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_conv),
    .wr_data (reg_wdata),
    .value   (conv_mode)
  );

  reg8_cell #(
    .RESET_VALUE (CFG_RESET),
    .WRITE_MASK  (FULL_MASK)
  ) u_ldo1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_ldo1),
    .wr_data (reg_wdata),
    .value   (first_ldo_config)
  );

  // ----------------------------------------------------------------
  // field unpacking; index 0 is regulator five
  // ----------------------------------------------------------------
  wire [21:0] pairs;
  wire [10:0] next_output_on;
  wire [10:0] next_low_power;

  assign pairs = {group4[5:0], group3, group2};

  // bit 2i+1 of the pairs is the enable, bit 2i the low-power bit
  genvar i;
  generate
    for (i = 0; i < NUM_LDO; i = i + 1) begin : g_ldo
      assign next_output_on[i] = pairs[2*i+1];
      assign next_low_power[i] = pairs[2*i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // registered once more so every port comes from a flip-flop;
  // costs one cycle of latency after the write
  always @(posedge clk) begin
    if (sys_rst) begin
      ldo_output_on         <= pick(RESET_PAIRS, 1'b1);
      ldo_low_power         <= pick(RESET_PAIRS, 1'b0);
      buckboost_output_on   <= CONV_RESET[`POS_BUCKBOOST_ON];
      buck_output_on        <= CONV_RESET[`POS_BUCK_ON];
      buck_low_power        <= CONV_RESET[`POS_BUCK_LOW_POWER];
      reg1_active_discharge <= CFG_RESET[`POS_ACTIVE_DISCHARGE];
      reg1_voltage_code     <= CFG_RESET[`POS_VOLTAGE_CODE_MSB:0];
    end else begin
      ldo_output_on         <= next_output_on;
      ldo_low_power         <= next_low_power;
      buckboost_output_on   <= conv_mode[`POS_BUCKBOOST_ON];
      buck_output_on        <= conv_mode[`POS_BUCK_ON];
      buck_low_power        <= conv_mode[`POS_BUCK_LOW_POWER];
      reg1_active_discharge <= first_ldo_config[`POS_ACTIVE_DISCHARGE];
      reg1_voltage_code     <= first_ldo_config[`POS_VOLTAGE_CODE_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // a read racing a write to the same address sees the old value
  reg [7:0] next_rdata;
  always @* begin
    case (reg_addr)
      `OFF_LDO_MODE_GROUP2:  next_rdata = group2;
      `OFF_LDO_MODE_GROUP3:  next_rdata = group3;
      `OFF_LDO_MODE_GROUP4:  next_rdata = group4;
      `OFF_CONVERTER_MODE:   next_rdata = conv_mode;
      `OFF_FIRST_LDO_CONFIG: next_rdata = first_ldo_config;
      default:               next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // regulator_mode_config_regs
`default_nettype wire

// File: rtl/regulator_mode_config_regs.vh
/*
 * Register offsets, field positions and reset values for the regulator
 * mode and first-regulator configuration registers.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef REGULATOR_MODE_CONFIG_REGS_VH
`define REGULATOR_MODE_CONFIG_REGS_VH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFF_LDO_MODE_GROUP2   8'h11
`define OFF_LDO_MODE_GROUP3   8'h12
`define OFF_LDO_MODE_GROUP4   8'h13
`define OFF_CONVERTER_MODE    8'h14
`define OFF_FIRST_LDO_CONFIG  8'h20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_LDO_MODE          8'h00
`define RST_CONVERTER_MODE    8'h00
`define RST_FIRST_LDO_CONFIG  8'ha0

// ----------------------------------------------------------------
// writable bit masks and field positions
// ----------------------------------------------------------------
`define MASK_LDO_MODE_GROUP4  8'h3f
`define MASK_CONVERTER_MODE   8'h0b
`define POS_BUCKBOOST_ON      3
`define POS_BUCK_ON           1
`define POS_BUCK_LOW_POWER    0
`define POS_ACTIVE_DISCHARGE  7
`define POS_VOLTAGE_CODE_MSB  6

`endif

// File: rtl/reg8_cell.v
/*
 * One 8-bit control register with a write mask and reset value.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module reg8_cell #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK  = 8'hff
) (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // stored value
  output reg  [7:0] value
);

  // reserved bits stay at their reset level, writes to them are dropped
  always @(posedge clk) begin
    if (sys_rst)
      value <= RESET_VALUE;
    else if (wr_en)
      value <= (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
  end

endmodule // reg8_cell
`default_nettype wire

// File: testbench/reg_host.sv
/* host bus master model driving one-cycle strobes.
   assumes the block samples strobes on rising clk. */
`timescale 1ns/10ps
`default_nettype none
module reg_host (
  // strobe bus
  input  wire logic       clk,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  // released lines flip so a stale value never matches
  task automatic put(input logic [7:0] a, d, input logic w);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'h0};
  endtask
endmodule // reg_host
`default_nettype wire

// File: testbench/regulator_mode_config_regs_monitor.sv
/* port assertions for the regulator register block.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module regulator_mode_config_regs_monitor (
  // bus
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // controls
  input wire logic [10:0] ldo_output_on,
  input wire logic [10:0] ldo_low_power,
  input wire logic        buckboost_output_on,
  input wire logic        buck_output_on,
  input wire logic        buck_low_power,
  input wire logic        reg1_active_discharge,
  input wire logic [6:0]  reg1_voltage_code
);
  logic [7:0] w1, w2;
  wire  [7:0] sw = {w2[7], w2[5], w2[3], w2[1], w2[6], w2[4], w2[2], w2[0]};
  wire [10:0] on = ldo_output_on;
  wire [10:0] lp = ldo_low_power;
  // outputs trail the write strobe by two edges
  always @(posedge clk) {w2, w1} <= {w1, reg_wdata};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr1(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  grp2_map_a:
    assert property (wr1(8'h11) |=> {on[3:0], lp[3:0]} == sw) else $error("m");
  grp3_map_a:
    assert property (wr1(8'h12) |=> {on[7:4], lp[7:4]} == sw) else $error("m");
  grp4_map_a:
    assert property (wr1(8'h13) |=> {on[10:8], lp[10:8]} ==
      {sw[6:4], sw[2:0]}) else $error("m");
  conv_map_a:
    assert property (wr1(8'h14) |=> {buckboost_output_on, buck_output_on,
      buck_low_power} == {w2[3], w2[1], w2[0]}) else $error("m");
  cfg_map_a:
    assert property (wr1(8'h20) |=> {reg1_active_discharge,
      reg1_voltage_code} == w2) else $error("m");
  rsvd_zero_a:
    assert property (reg_rd && reg_addr == 8'h14 |=> !(reg_rdata & 8'hf4))
      else $error("m");
  grp4_rsvd_a:
    assert property (reg_rd && reg_addr == 8'h13 |=> !(reg_rdata & 8'hc0))
      else $error("mode group four reserved bits read nonzero");
  unmapped_zero_a:
    assert property (reg_rd && reg_addr inside {[8'h15:8'h1f]} |=> !reg_rdata)
      else $error("m");
  reset_val_a:
    assert property ($fell(sys_rst) |-> !{on, lp, buckboost_output_on,
      buck_output_on, buck_low_power} && reg1_voltage_code == 7'h20
      && reg1_active_discharge) else $error("m");
  cover property (wr1(8'h14));
  cover property (reg_rd && reg_addr == 8'h1f);
  cover property ($fell(sys_rst));
endmodule // regulator_mode_config_regs_monitor
bind regulator_mode_config_regs regulator_mode_config_regs_monitor u_mon (.*);
`default_nettype wire

// File: testbench/regulator_mode_config_regs_tb.sv
/* bench for the regulator register block.
   assumes reg_host drives the strobe bus. */
`timescale 1ns/10ps
`default_nettype none
module regulator_mode_config_regs_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, buckboost_output_on, buck_output_on;
  logic        buck_low_power, reg1_active_discharge;
  logic [10:0] ldo_output_on, ldo_low_power;
  logic [6:0]  reg1_voltage_code;
  int          fails = 0;
  int          num_checks = 0;
  // address, written value, read-back value
  logic [23:0] t[7] = '{24'h119696, 24'h122d2d, 24'h13f939, 24'h14fd09,
    24'h207f7f, 24'h15ff00, 24'h1fff00};
  wire  [32:0] outs = {ldo_output_on, ldo_low_power, buckboost_output_on,
    buck_output_on, buck_low_power, reg1_active_discharge, reg1_voltage_code};
  always #5 clk = ~clk;
  regulator_mode_config_regs u_regulator_mode_config_regs (.*);
  reg_host u_reg_host (.*);
  task automatic check(input logic [32:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    u_reg_host.put(a, 8'h00, 1'b0);
    check(reg_rdata, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      check(outs, {25'h0, 8'ha0});
      foreach (t[i]) rd_chk(t[i][23:16], i == 4 ? 8'ha0 : 8'h00);
      foreach (t[i])
        u_reg_host.put(t[i][23:16], t[i][15:8], 1'b1);
      foreach (t[i]) rd_chk(t[i][23:16], t[i][7:0]);
      check(outs, {11'h669, 11'h536, 3'h5, 8'h7f});
      $display("pass %0d done", p);
      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
    end
    print_verdict;
  end
endmodule // regulator_mode_config_regs_tb
`default_nettype wire
